//--- rtl/vflr_pkg.sv
/*
  vflr_pkg: command codes, field positions, reset values, state and
  carrier types for the output-voltage limit and fault-reaction block.
  Assumes a command-port front end that has already decoded the
  management-bus transaction into one code and one data word.
*/
package vflr_pkg;

  // command codes of the register bank
  localparam logic [7:0] CODE_CURRENT_READING_OFFSET = 8'h39;
  localparam logic [7:0] CODE_OV_FAULT_THRESHOLD = 8'h40;
  localparam logic [7:0] CODE_OV_FAULT_REACTION = 8'h41;
  localparam logic [7:0] CODE_OV_WARNING_THRESHOLD = 8'h42;
  localparam logic [7:0] CODE_UV_WARNING_THRESHOLD = 8'h43;
  // time-unit command lives outside this block; its tick arrives on a pin
  localparam logic [7:0] CODE_DELAY_TIME_UNIT = 8'hD2;

  // reaction byte fields
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  // response codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_HOLD_OFF = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // values after reset
  localparam logic [15:0] RST_CURRENT_OFFSET = 16'h0000;
  localparam logic [15:0] RST_OV_FAULT_THRESHOLD = 16'hFFFF;
  localparam logic [7:0] RST_OV_FAULT_REACTION = 8'h80;
  localparam logic [15:0] RST_OV_WARNING_THRESHOLD = 16'hFFFF;
  localparam logic [15:0] RST_UV_WARNING_THRESHOLD = 16'h0000;

  // status flag positions
  localparam int FLAG_OV_FAULT = 0;
  localparam int FLAG_OV_WARN = 1;
  localparam int FLAG_UV_WARN = 2;
  localparam int NUM_FLAGS = 3;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DELAY = 3'b001,
    ST_RETRY_WAIT = 3'b010,
    ST_LATCHED = 3'b011,
    ST_HOLD_OFF = 3'b100
  } vflr_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } vflr_cmd_s;

  typedef struct packed {
    logic ack;
    logic nak;
    logic [15:0] rdata;
  } vflr_rsp_s;

endpackage : vflr_pkg

//--- rtl/vflr_limit_bank.sv
/*
  vflr_limit_bank: current-reading offset, output-voltage limits and the
  over-voltage fault reaction engine, reached through a decoded command port.
  Assumes measurement words arrive synchronous to core_clk, in the same
  units as the limits, and that an external time-unit timer supplies one
  pulse per delay unit on delay_unit_tick.
*/
// Summary of operation
// (R1) reported output current equals raw reading plus the programmed offset
// (R2) over-voltage fault threshold held as 16-bit unsigned, exponent -11
// (R3) over-voltage warning threshold held as 16-bit unsigned, exponent -11
// (R4) under-voltage warning threshold held as 16-bit unsigned, exponent -11
// (R5) response code 00: keep converting, ignore the over-voltage fault
// (R6) code 01: run on for the delay, then act per retry field
// (R7) code 10: disable output at once, then follow retry field
// (R8) code 11: output off only while fault lasts, then resumes
// (R9) reaction bits 5:3 give number of restart attempts after shutdown
// (R10) retry value 000 allows no restart at all
// (R11) with no restart left, output stays off until fault is cleared
// (R12) retry value 111 restarts endlessly while the fault recurs
// (R13) bits 2:0 select delay of two to the field power units
// (R14) same delay serves run-on time and gap between restart attempts
// (R15) delay unit length comes from the separate time-unit command
// (R16) alert pin pulled for any unmasked latched fault or warning
// (R17) over-voltage above threshold, under-voltage below threshold
// (R18) each detection latched in a flag until the host clears it
`timescale 1ns/1ns
`default_nettype none

module vflr_limit_bank #(
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire vflr_pkg::vflr_cmd_s cmd,
  output vflr_pkg::vflr_rsp_s rsp,
  input wire logic [DATA_W-1:0] vout_meas,
  input wire logic [DATA_W-1:0] output_current_raw,
  input wire logic delay_unit_tick,
  input wire logic [vflr_pkg::NUM_FLAGS-1:0] alert_mask,
  input wire logic [vflr_pkg::NUM_FLAGS-1:0] status_clear,
  output logic [DATA_W-1:0] output_current,
  output logic [vflr_pkg::NUM_FLAGS-1:0] status_flags,
  output logic output_enable,
  output logic shared_alert_output_o,
  output logic shared_alert_output_oe
);

  // delay of 2**field units; 128 still fits eight bits
  function automatic logic [7:0] delay_units(input logic [2:0] field);
    delay_units = 8'(9'h001 << field);
  endfunction : delay_units

  logic [1:0] rst_sync_reg;
  logic rst_int_n;
  logic [DATA_W-1:0] current_reading_offset_reg;
  logic [DATA_W-1:0] overvoltage_fault_threshold_reg;
  logic [7:0] overvoltage_fault_reaction_reg;
  logic [DATA_W-1:0] overvoltage_warning_threshold_reg;
  logic [DATA_W-1:0] undervoltage_warning_threshold_reg;
  logic [vflr_pkg::NUM_FLAGS-1:0] status_flags_reg;
  logic [vflr_pkg::NUM_FLAGS-1:0] detect;
  vflr_pkg::vflr_state_e state_reg;
  vflr_pkg::vflr_state_e state_next;
  logic [7:0] delay_cnt_reg;
  logic [2:0] retries_left_reg;
  logic [DATA_W-1:0] output_current_reg;
  logic output_enable_reg;
  logic alert_reg;
  vflr_pkg::vflr_rsp_s rsp_reg;
  logic wr_en;
  logic ov_fault;
  logic [1:0] resp_code;
  logic [2:0] retry_field;
  logic [2:0] delay_field;
  logic delay_expired;
  logic start_delay;
  logic restart_now;
  logic reload_retries;

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_reg[1];

  assign wr_en = cmd.valid && cmd.write;
  assign resp_code = overvoltage_fault_reaction_reg[vflr_pkg::RESP_HI:vflr_pkg::RESP_LO];
  assign retry_field = overvoltage_fault_reaction_reg[vflr_pkg::RETRY_HI:vflr_pkg::RETRY_LO];
  assign delay_field = overvoltage_fault_reaction_reg[vflr_pkg::DELAY_HI:vflr_pkg::DELAY_LO];

  // command writes
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      current_reading_offset_reg <= vflr_pkg::RST_CURRENT_OFFSET;
      overvoltage_fault_threshold_reg <= vflr_pkg::RST_OV_FAULT_THRESHOLD;
      overvoltage_fault_reaction_reg <= vflr_pkg::RST_OV_FAULT_REACTION;
      overvoltage_warning_threshold_reg <= vflr_pkg::RST_OV_WARNING_THRESHOLD;
      undervoltage_warning_threshold_reg <= vflr_pkg::RST_UV_WARNING_THRESHOLD;
    end else if (wr_en) begin
      unique case (cmd.code)
        vflr_pkg::CODE_CURRENT_READING_OFFSET: begin
          current_reading_offset_reg <= cmd.wdata; // R1
        end
        vflr_pkg::CODE_OV_FAULT_THRESHOLD: begin
          overvoltage_fault_threshold_reg <= cmd.wdata; // R2
        end
        vflr_pkg::CODE_OV_FAULT_REACTION: begin
          overvoltage_fault_reaction_reg <= cmd.wdata[7:0];
        end
        vflr_pkg::CODE_OV_WARNING_THRESHOLD: begin
          overvoltage_warning_threshold_reg <= cmd.wdata; // R3
        end
        vflr_pkg::CODE_UV_WARNING_THRESHOLD: begin
          undervoltage_warning_threshold_reg <= cmd.wdata; // R4
        end
        default: begin
        end
      endcase
    end
  end

  // command reads and refusals; answer one cycle after the request
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack <= 1'b0;
      rsp_reg.nak <= 1'b0;
      if (cmd.valid) begin
        rsp_reg.ack <= 1'b1;
        unique case (cmd.code)
          vflr_pkg::CODE_CURRENT_READING_OFFSET: begin
            rsp_reg.rdata <= current_reading_offset_reg;
          end
          vflr_pkg::CODE_OV_FAULT_THRESHOLD: begin
            rsp_reg.rdata <= overvoltage_fault_threshold_reg;
          end
          vflr_pkg::CODE_OV_FAULT_REACTION: begin
            rsp_reg.rdata <= {8'h00, overvoltage_fault_reaction_reg};
          end
          vflr_pkg::CODE_OV_WARNING_THRESHOLD: begin
            rsp_reg.rdata <= overvoltage_warning_threshold_reg;
          end
          vflr_pkg::CODE_UV_WARNING_THRESHOLD: begin
            rsp_reg.rdata <= undervoltage_warning_threshold_reg;
          end
          default: begin
            rsp_reg.ack <= 1'b0;
            rsp_reg.nak <= 1'b1;
            rsp_reg.rdata <= 16'h0000;
          end
        endcase
      end
    end
  end
  assign rsp = rsp_reg;

  // plain two's complement add: offset and reading share one scale
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      output_current_reg <= '0;
    end else begin
      output_current_reg <= output_current_raw + current_reading_offset_reg; // R1
    end
  end
  assign output_current = output_current_reg;

  // limit comparison, strict in both directions
  assign ov_fault = vout_meas > overvoltage_fault_threshold_reg; // R17
  assign detect[vflr_pkg::FLAG_OV_FAULT] = ov_fault; // R17
  assign detect[vflr_pkg::FLAG_OV_WARN] = vout_meas > overvoltage_warning_threshold_reg; // R17
  assign detect[vflr_pkg::FLAG_UV_WARN] = vout_meas < undervoltage_warning_threshold_reg; // R17

  // a detection in the clearing cycle keeps its flag set
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      status_flags_reg <= '0;
    end else begin
      status_flags_reg <= (status_flags_reg & ~status_clear) | detect; // R18
    end
  end
  assign status_flags = status_flags_reg;

  // open-drain alert: enable high pulls the shared line low
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |(status_flags_reg & ~alert_mask); // R16
    end
  end
  assign shared_alert_output_oe = alert_reg;
  assign shared_alert_output_o = 1'b0;

  // delay counter: loaded with 2**field, one count per external unit tick
  assign delay_expired = delay_unit_tick && (delay_cnt_reg == 8'h01); // R15
  assign start_delay = (state_next != state_reg)
                       && ((state_next == vflr_pkg::ST_DELAY)
                           || (state_next == vflr_pkg::ST_RETRY_WAIT));

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      delay_cnt_reg <= 8'h00;
    end else if (start_delay) begin
      delay_cnt_reg <= delay_units(delay_field); // R13 R14
    end else if (delay_unit_tick && (delay_cnt_reg != 8'h00)) begin
      delay_cnt_reg <= delay_cnt_reg - 8'h01; // R15
    end
  end

  // fault episode ends when the host clears the latched fault flag while the over-voltage is gone
  assign reload_retries = status_clear[vflr_pkg::FLAG_OV_FAULT] && !ov_fault;
  assign restart_now = (state_reg == vflr_pkg::ST_RETRY_WAIT) && delay_expired;

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      retries_left_reg <= 3'h0;
    end else if (wr_en && (cmd.code == vflr_pkg::CODE_OV_FAULT_REACTION)) begin
      // a new reaction byte brings its own retry budget
      retries_left_reg <= cmd.wdata[vflr_pkg::RETRY_HI:vflr_pkg::RETRY_LO]; // R9
    end else if (reload_retries || (state_reg == vflr_pkg::ST_LATCHED && state_next
                                    == vflr_pkg::ST_RUN)) begin
      retries_left_reg <= retry_field; // R9
    end else if (restart_now && (retry_field != vflr_pkg::RETRY_FOREVER)
                 && (retries_left_reg != 3'h0)) begin
      // a budget cut by a rewrite during a wait must not wrap to seven
      retries_left_reg <= retries_left_reg - 3'h1; // R9 R12
    end
  end

  // shutdown outcome shared by codes 01 and 10
  function automatic vflr_pkg::vflr_state_e after_shutdown(input logic [2:0] retries);
    if (retry_field == vflr_pkg::RETRY_FOREVER) begin
      after_shutdown = vflr_pkg::ST_RETRY_WAIT; // R12
    end else if (retries == vflr_pkg::RETRY_NONE) begin
      after_shutdown = vflr_pkg::ST_LATCHED; // R10 R11
    end else begin
      after_shutdown = vflr_pkg::ST_RETRY_WAIT; // R9
    end
  endfunction : after_shutdown

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      vflr_pkg::ST_RUN: begin
        if (ov_fault) begin
          unique case (resp_code)
            vflr_pkg::RESP_IGNORE: state_next = vflr_pkg::ST_RUN; // R5
            vflr_pkg::RESP_DELAYED: state_next = vflr_pkg::ST_DELAY; // R6
            vflr_pkg::RESP_SHUTDOWN: state_next = after_shutdown(retries_left_reg); // R7
            vflr_pkg::RESP_HOLD_OFF: state_next = vflr_pkg::ST_HOLD_OFF; // R8
          endcase
        end
      end
      vflr_pkg::ST_DELAY: begin
        // output stays on while the run-on time elapses
        if (!ov_fault) begin
          state_next = vflr_pkg::ST_RUN;
        end else if (delay_expired) begin
          state_next = after_shutdown(retries_left_reg); // R6 R14
        end
      end
      vflr_pkg::ST_RETRY_WAIT: begin
        if (delay_expired) begin
          state_next = vflr_pkg::ST_RUN; // R9 R14
        end
      end
      vflr_pkg::ST_LATCHED: begin
        // only a host clear with the condition gone lets it restart
        if (reload_retries) begin
          state_next = vflr_pkg::ST_RUN; // R11
        end
      end
      vflr_pkg::ST_HOLD_OFF: begin
        if (!ov_fault) begin
          state_next = vflr_pkg::ST_RUN; // R8
        end
      end
      default: begin
        state_next = vflr_pkg::ST_LATCHED;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_reg <= vflr_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // output enable follows the next state so shutdown lands with the fault edge
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      output_enable_reg <= 1'b1;
    end else begin
      output_enable_reg <= (state_next == vflr_pkg::ST_RUN)
                           || (state_next == vflr_pkg::ST_DELAY); // R5 R6 R7 R8
    end
  end
  assign output_enable = output_enable_reg;

endmodule : vflr_limit_bank

`default_nettype wire

//--- test/vflr_limit_bank_chk.sv
/* vflr_limit_bank_chk: port-level assertions for vflr_limit_bank.
   Assumes it is bound to the design top; rst_n is the raw async reset. */
`timescale 1ns/1ns
`default_nettype none
module vflr_limit_bank_chk #(
  parameter int DATA_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire vflr_pkg::vflr_cmd_s cmd,
  input wire vflr_pkg::vflr_rsp_s rsp,
  input wire logic [DATA_W-1:0] vout_meas,
  input wire logic [DATA_W-1:0] output_current_raw,
  input wire logic delay_unit_tick,
  input wire logic [vflr_pkg::NUM_FLAGS-1:0] alert_mask,
  input wire logic [vflr_pkg::NUM_FLAGS-1:0] status_clear,
  input wire logic [DATA_W-1:0] output_current,
  input wire logic [vflr_pkg::NUM_FLAGS-1:0] status_flags,
  input wire logic output_enable,
  input wire logic shared_alert_output_o,
  input wire logic shared_alert_output_oe
);
  logic [1:0] up;
  logic [DATA_W-1:0] off_m;
  logic [15:0] ovf_m;
  logic [7:0] rx_m;
  wire logic wr = cmd.valid && cmd.write;
  wire logic rdy = up == 2'h3;
  wire logic known = cmd.code inside {8'h39, 8'h40, 8'h41, 8'h42, 8'h43};
  // internal reset trails rst_n by two edges, so checks wait for it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
      off_m <= '0;
      ovf_m <= 16'hFFFF;
      rx_m <= 8'h80;
    end else begin
      if (!rdy) up <= up + 2'h1;
      if (wr && cmd.code == 8'h39) off_m <= cmd.wdata;
      if (wr && cmd.code == 8'h40) ovf_m <= cmd.wdata;
      if (wr && cmd.code == 8'h41) rx_m <= cmd.wdata[7:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ovf_readback_a: assert property (rdy && cmd.valid && !cmd.write && cmd.code == 8'h40
    |=> rsp.ack && rsp.rdata == ovf_m) else $error("fault threshold read wrong");
  reaction_readback_a: assert property (rdy && cmd.valid && !cmd.write && cmd.code == 8'h41
    |=> rsp.ack && rsp.rdata == {8'h00, rx_m}) else $error("reaction byte read wrong");
  unknown_nak_a: assert property (rdy && cmd.valid && !known
    |=> rsp.nak && !rsp.ack && rsp.rdata == 16'h0000) else $error("unknown code not refused");
  offset_sum_a: assert property (rdy && $past(rdy) && !$past(cmd.valid)
    |-> output_current == $past(output_current_raw + off_m)) else $error("current offset wrong");
  alert_follow_a: assert property (rdy && $past(rdy)
    |-> shared_alert_output_oe == |($past(status_flags) & ~$past(alert_mask)))
    else $error("alert pull wrong");
  alert_data_low_a: assert property (shared_alert_output_o == 1'b0)
    else $error("alert data not low");
  ovf_detect_a: assert property (rdy && vout_meas > ovf_m |=> status_flags[0])
    else $error("fault flag not set");
  flag_sticky_a: assert property (rdy && status_flags[1] && !status_clear[1]
    |=> status_flags[1]) else $error("warning flag lost");
  ignore_keeps_on_a: assert property (rdy && rx_m[7:6] == 2'h0 && output_enable
    |=> output_enable) else $error("output dropped while ignoring");
  shutdown_now_a: assert property (rdy && rx_m[7:6] == 2'h2 && output_enable
    && vout_meas > ovf_m |=> !output_enable) else $error("output not cut at once");
endmodule : vflr_limit_bank_chk
bind vflr_limit_bank vflr_limit_bank_chk #(.DATA_W(DATA_W)) chk_i (.core_clk, .rst_n, .cmd,
  .rsp, .vout_meas, .output_current_raw, .delay_unit_tick, .alert_mask, .status_clear,
  .output_current, .status_flags, .output_enable, .shared_alert_output_o,
  .shared_alert_output_oe);
`default_nettype wire

//--- test/vflr_host.sv
/* vflr_host: host model issuing decoded commands to the limit bank.
   Assumes the answer comes one cycle after the taking edge. */
`timescale 1ns/1ns
`default_nettype none
module vflr_host (
  input wire logic core_clk,
  output var vflr_pkg::vflr_cmd_s cmd,
  input wire vflr_pkg::vflr_rsp_s rsp
);
  initial cmd = '0;
  // idle lines carry inverted data so stale values never pass for fresh ones
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic k, output logic n);
    @(posedge core_clk);
    cmd <= '{valid: 1'b1, write: w, code: c, wdata: d};
    @(posedge core_clk);
    cmd <= '{valid: 1'b0, write: ~w, code: ~c, wdata: ~d};
    @(posedge core_clk);
    q = rsp.rdata;
    k = rsp.ack;
    n = rsp.nak;
  endtask : xfer
endmodule : vflr_host
`default_nettype wire

//--- test/tb_vflr_limit_bank.sv
/* tb_vflr_limit_bank: self-checking bench for the limit and reaction block.
   Assumes the host model drives the command port. */
`timescale 1ns/1ns
`default_nettype none
module tb_vflr_limit_bank;
  typedef struct {logic [7:0] c; logic [15:0] r, d, e;} vflr_row_s;
  logic core_clk = 0, rst_n = 0, delay_unit_tick = 0, output_enable, a_o, a_oe, k, n;
  vflr_pkg::vflr_cmd_s cmd;
  vflr_pkg::vflr_rsp_s rsp;
  logic [15:0] vout_meas = 16'h4000, output_current_raw = 16'h0000, output_current, q;
  logic [2:0] alert_mask = 3'h0, status_clear = 3'h0, status_flags;
  int fail_count = 0, total_checks = 0, rises = 0;
  vflr_row_s rows[7] = '{'{8'h39, 16'h0000, 16'h1234, 16'h1234},
    '{8'h40, 16'hFFFF, 16'h8000, 16'h8000}, '{8'h41, 16'h0080, 16'h01D1, 16'h00D1},
    '{8'h42, 16'hFFFF, 16'h7000, 16'h7000}, '{8'h43, 16'h0000, 16'h1000, 16'h1000},
    '{8'h44, 16'h0000, 16'h5555, 16'h0000}, '{8'hD2, 16'h0000, 16'h0003, 16'h0000}};
  vflr_limit_bank vflr_limit_bank_i (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd),
    .rsp(rsp), .vout_meas(vout_meas), .output_current_raw(output_current_raw),
    .delay_unit_tick(delay_unit_tick), .alert_mask(alert_mask), .status_clear(status_clear),
    .output_current(output_current), .status_flags(status_flags),
    .output_enable(output_enable), .shared_alert_output_o(a_o), .shared_alert_output_oe(a_oe));
  vflr_host vflr_host_i (.core_clk(core_clk), .cmd(cmd), .rsp(rsp));
  always #50 core_clk = ~core_clk;
  always @(posedge output_enable) rises++;
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cyc
  task automatic tick(input int c);
    repeat (c) begin
      @(posedge core_clk) delay_unit_tick <= 1'b1;
      @(posedge core_clk) delay_unit_tick <= 1'b0;
      cyc(2);
    end
  endtask : tick
  // back to a quiet output with a new reaction byte, then flags cleared
  task automatic react(input logic [7:0] b);
    vout_meas <= 16'h4000;
    vflr_host_i.xfer(1'b1, 8'h41, {8'h00, b}, q, k, n);
    // one tick ends a retry wait left over from the previous case
    tick(1);
    @(posedge core_clk) status_clear <= 3'h7;
    @(posedge core_clk) status_clear <= 3'h0;
    cyc(3);
    rises = 0;
  endtask : react
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    summarize();
  end
  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      vflr_host_i.xfer(1'b0, rows[i].c, 16'h0000, q, k, n);
      chk($sformatf("reset %h", rows[i].c), rows[i].r, q);
      vflr_host_i.xfer(1'b1, rows[i].c, rows[i].d, q, k, n);
      vflr_host_i.xfer(1'b0, rows[i].c, 16'h0000, q, k, n);
      chk($sformatf("read %h", rows[i].c), rows[i].e, q);
      chk($sformatf("nak %h", rows[i].c), {15'h0, rows[i].c > 8'h43}, {15'h0, n});
      chk($sformatf("ack %h", rows[i].c), {15'h0, rows[i].c <= 8'h43}, {15'h0, k});
    end
    output_current_raw <= 16'hF000;
    cyc(3);
    chk("current", 16'h0234, output_current);
    vout_meas <= 16'h7800;
    cyc(3);
    chk("ov warn flag", 16'h0002, {13'h0, status_flags});
    chk("alert", 16'h0001, {15'h0, a_oe});
    alert_mask <= 3'h2;
    cyc(3);
    chk("masked alert", 16'h0000, {15'h0, a_oe});
    vout_meas <= 16'h0800;
    cyc(3);
    chk("uv flag", 16'h0006, {13'h0, status_flags});
    alert_mask <= 3'h0;
    react(8'h00);
    vout_meas <= 16'h9000;
    cyc(5);
    chk("ignore", 16'h0001, {15'h0, output_enable});
    react(8'h80);
    vout_meas <= 16'h9000;
    cyc(2);
    chk("cut", 16'h0000, {15'h0, output_enable});
    chk("ov fault flag", 16'h0003, {13'h0, status_flags});
    vout_meas <= 16'h4000;
    tick(3);
    chk("no retry", 16'h0000, {15'h0, output_enable});
    @(posedge core_clk) status_clear <= 3'h1;
    @(posedge core_clk) status_clear <= 3'h0;
    cyc(3);
    chk("cleared", 16'h0001, {15'h0, output_enable});
    react(8'h90);
    vout_meas <= 16'h9000;
    tick(12);
    chk("restarts", 16'h0002, rises[15:0]);
    react(8'hB8);
    vout_meas <= 16'h9000;
    tick(12);
    chk("endless", 16'h0001, {15'h0, rises > 6});
    react(8'h42);
    vout_meas <= 16'h9000;
    tick(3);
    chk("run on", 16'h0001, {15'h0, output_enable});
    tick(1);
    chk("delay end", 16'h0000, {15'h0, output_enable});
    react(8'hC0);
    vout_meas <= 16'h9000;
    cyc(2);
    chk("hold off", 16'h0000, {15'h0, output_enable});
    vout_meas <= 16'h4000;
    cyc(3);
    chk("resume", 16'h0001, {15'h0, output_enable});
    rst_n <= 1'b0;
    cyc(2);
    chk("reset flags", 16'h0000, {13'h0, status_flags});
    rst_n <= 1'b1;
    cyc(4);
    vflr_host_i.xfer(1'b0, 8'h40, 16'h0000, q, k, n);
    chk("reset limit", 16'hFFFF, q);
    summarize();
  end
endmodule : tb_vflr_limit_bank
`default_nettype wire
